/* File: logic/ipec_top.v */
// interrupt priority and extended-enable block: priority bits, extended
// enables, external input pin/polarity selection and gated request outputs
// assumes a single-cycle special-function bus from the core, flags from the
// peripherals as synchronous levels, and port 0 pins already synchronised
//
// Overview of operation
// - base priority bit 7 reads one, ignores writes
// - base bits 6..0 set seven source priorities
// - timer three enable gates both overflow flags
// - extended enable bits 6,1 read zero
// - comparator enable gates rise and fall flags
// - counter array enable gates all its requests
// - conversion done enable gates its flag
// - window compare enable gates its flag
// - two-wire enable gates all its requests
// - extended priority bits 5,4,3,0 set levels
// - window compare priority bit sets its level
// - input one polarity: zero low, one high
// - input one select picks port zero pin
// - input zero polarity: zero low, one high
// - input zero select picks port zero pin
// - pins sampled without disturbing crossbar routing
// - crossbar skip mask frees selected pins
// - global enable overrides every individual mask at the core request, not at ext_req_o
// - requests sampled and decoded every cycle
// - equal or higher service in progress blocks
`timescale 1ns/1ns
`default_nettype none
`include "ipec_defines.vh"

module ipec_top #(
    parameter PORT_W = 8
) (
    // clock and reset
    input wire sys_clk_i,
    input wire srst_i,
    // special-function register bus
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    output reg sfr_ack_o,
    // global enable from the base enable register
    input wire global_irq_enable_i,
    // raw base source requests, bits 6..0 in base priority order
    input wire [6:0] base_req_i,
    // extended source flags
    input wire timer_three_low_ovf_i,
    input wire timer_three_high_ovf_i,
    input wire comparator_rise_flag_i,
    input wire comparator_fall_flag_i,
    input wire counter_array_req_i,
    input wire conv_done_flag_i,
    input wire window_cmp_flag_i,
    input wire two_wire_req_i,
    // core service state: level of the routine now running
    input wire svc_low_active_i,
    input wire svc_high_active_i,
    // port 0 pins and crossbar skip mask
    input wire [PORT_W-1:0] port_zero_pins_i,
    input wire [PORT_W-1:0] port_zero_skip_mask_i,
    // external inputs, active high after polarity correction
    output reg ext_input_zero_o,
    output reg ext_input_one_o,
    // pins the crossbar must not route: registered copy of the skip mask, not the input selections
    output reg [PORT_W-1:0] xbar_block_o,
    // gated extended requests and their levels
    output reg [5:0] ext_req_o,
    output reg [5:0] ext_prio_o,
    // base priorities
    output reg [6:0] base_prio_o,
    // request to the core, with its level
    output reg irq_req_o,
    output reg irq_high_o
);

    // register state: one flop group per register; bit 7 of the base
    // priority register has no storage because it always reads as one
    reg [6:0] base_prio_q; // base priorities, bit 7 not stored
    reg [7:0] pin_cfg_q; // pin selection and polarity
    reg [7:0] ext_en_q; // extended enables, reserved bits held at zero
    reg [7:0] ext_prio_q; // extended priorities, reserved bits held at zero
    reg [7:0] rdata_d; // read data chosen this cycle, registered below

    // reset image of the base priority register; only bits 6..0 are kept
    wire [7:0] base_rst;
    assign base_rst = `IPEC_RST_BASE_PRIO;

    // write decode: one strobe per register, foreign addresses match none
    wire wr_base; // write to the base priority register
    wire wr_cfg; // write to the pin configuration register
    wire wr_en; // write to the extended enable register
    wire wr_prio; // write to the extended priority register
    assign wr_base = sfr_wr_i & (sfr_addr_i == `IPEC_ADDR_BASE_PRIO);
    assign wr_cfg = sfr_wr_i & (sfr_addr_i == `IPEC_ADDR_PIN_CFG);
    assign wr_en = sfr_wr_i & (sfr_addr_i == `IPEC_ADDR_EXT_EN);
    assign wr_prio = sfr_wr_i & (sfr_addr_i == `IPEC_ADDR_EXT_PRIO);

    // read views
    wire [7:0] base_rd;
    wire [7:0] ext_en_rd;
    wire [7:0] ext_prio_rd;
    // the unused top bit is forced high on every read
    assign base_rd = `IPEC_BASE_UNUSED | {1'b0, base_prio_q};
    // reserved bits are masked again on the way out as a second guard
    assign ext_en_rd = ext_en_q & `IPEC_EXT_WMASK;
    assign ext_prio_rd = ext_prio_q & `IPEC_EXT_WMASK;

    // base priority register: bit 7 of the write data is dropped, so a
    // write of either value leaves the read-as-one bit untouched
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            base_prio_q <= base_rst[6:0];
        end else if (wr_base) begin
            base_prio_q <= sfr_wdata_i[6:0];
        end
    end

    // pin configuration register: all eight bits are writable
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_cfg_q <= `IPEC_RST_PIN_CFG;
        end else if (wr_cfg) begin
            pin_cfg_q <= sfr_wdata_i;
        end
    end

    // extended enable register: reserved bits never store a one, even if
    // software breaks its side of the contract and writes them high
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            ext_en_q <= `IPEC_RST_EXT_EN;
        end else if (wr_en) begin
            ext_en_q <= sfr_wdata_i & `IPEC_EXT_WMASK;
        end
    end

    // extended priority register: same reserved-bit treatment as above
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            ext_prio_q <= `IPEC_RST_EXT_PRIO;
        end else if (wr_prio) begin
            ext_prio_q <= sfr_wdata_i & `IPEC_EXT_WMASK;
        end
    end

    // read multiplexer: foreign addresses and idle cycles give zero, so the
    // core may merge the read data of several blocks with a plain or
    always @* begin
        rdata_d = 8'h00;
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                `IPEC_ADDR_BASE_PRIO: rdata_d = base_rd;
                `IPEC_ADDR_PIN_CFG: rdata_d = pin_cfg_q;
                `IPEC_ADDR_EXT_EN: rdata_d = ext_en_rd;
                `IPEC_ADDR_EXT_PRIO: rdata_d = ext_prio_rd;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // bus answer: acknowledge and read data one cycle after the strobe,
    // both standing for exactly one cycle
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_ack_o <= 1'b0;
        end else begin
            sfr_rdata_o <= rdata_d;
            sfr_ack_o <= sfr_wr_i | sfr_rd_i;
        end
    end

    // pin selection fields
    wire [2:0] in0_sel;
    wire [2:0] in1_sel;
    assign in0_sel = pin_cfg_q[`IPEC_IN0_SEL_HI:`IPEC_IN0_SEL_LO];
    assign in1_sel = pin_cfg_q[`IPEC_IN1_SEL_HI:`IPEC_IN1_SEL_LO];

    // selected pins, read only: the pins themselves are never driven
    wire in0_pin;
    wire in1_pin;
    assign in0_pin = port_zero_pins_i[in0_sel];
    assign in1_pin = port_zero_pins_i[in1_sel];

    // polarity correction: a clear polarity bit marks the pin active low,
    // so it is inverted to give an active-high request level
    wire in0_act;
    wire in1_act;
    assign in0_act = pin_cfg_q[`IPEC_IN0_POL] ? in0_pin : ~in0_pin;
    assign in1_act = pin_cfg_q[`IPEC_IN1_POL] ? in1_pin : ~in1_pin;

    // per-pin crossbar block: skip mask only, selection does not steal pins
    wire [PORT_W-1:0] block_d;
    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_blk
            assign block_d[gi] = port_zero_skip_mask_i[gi];
        end
    endgenerate

    // extended gated requests, ordered timer3, comparator, counter array,
    // conversion done, window compare, two-wire
    reg [5:0] ext_req_d;
    reg [5:0] ext_prio_d;
    always @* begin
        ext_req_d[5] = ext_en_q[`IPEC_BIT_TIMER3] &
            (timer_three_low_ovf_i | timer_three_high_ovf_i);
        ext_req_d[4] = ext_en_q[`IPEC_BIT_COMPARATOR] &
            (comparator_rise_flag_i | comparator_fall_flag_i);
        ext_req_d[3] = ext_en_q[`IPEC_BIT_COUNTER_ARRAY] & counter_array_req_i;
        ext_req_d[2] = ext_en_q[`IPEC_BIT_CONV_DONE] & conv_done_flag_i;
        ext_req_d[1] = ext_en_q[`IPEC_BIT_WINDOW_CMP] & window_cmp_flag_i;
        ext_req_d[0] = ext_en_q[`IPEC_BIT_TWO_WIRE] & two_wire_req_i;
        ext_prio_d[5] = ext_prio_q[`IPEC_BIT_TIMER3];
        ext_prio_d[4] = ext_prio_q[`IPEC_BIT_COMPARATOR];
        ext_prio_d[3] = ext_prio_q[`IPEC_BIT_COUNTER_ARRAY];
        ext_prio_d[2] = ext_prio_q[`IPEC_BIT_CONV_DONE];
        ext_prio_d[1] = ext_prio_q[`IPEC_BIT_WINDOW_CMP];
        ext_prio_d[0] = ext_prio_q[`IPEC_BIT_TWO_WIRE];
    end

    // pending at each level, all sources; global enable masks only the combined levels, not ext_req_o
    wire base_high; // some base source pending at high level
    wire base_low; // some base source pending at low level
    wire ext_high; // some extended source pending at high level
    wire ext_low; // some extended source pending at low level
    wire any_high;
    wire any_low;
    assign base_high = |(base_req_i & base_prio_q);
    assign base_low = |(base_req_i & ~base_prio_q);
    assign ext_high = |(ext_req_d & ext_prio_d);
    assign ext_low = |(ext_req_d & ~ext_prio_d);
    // a cleared global enable wins over every individual enable bit
    assign any_high = global_irq_enable_i & (base_high | ext_high);
    assign any_low = global_irq_enable_i & (base_low | ext_low);

    // a high request may preempt only a low routine; low needs an idle core,
    // which the core side reports only after the return and one more
    // instruction, so a pending request waits out that instruction too
    wire take_high;
    wire take_low;
    assign take_high = any_high & ~svc_high_active_i;
    assign take_low = any_low & ~svc_high_active_i & ~svc_low_active_i;

    // external input outputs: polarity-corrected pin levels, one cycle late
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            ext_input_zero_o <= 1'b0;
            ext_input_one_o <= 1'b0;
        end else begin
            ext_input_zero_o <= in0_act;
            ext_input_one_o <= in1_act;
        end
    end

    // crossbar block mask: registered copy of the skip bits
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            xbar_block_o <= {PORT_W{1'b0}};
        end else begin
            xbar_block_o <= block_d;
        end
    end

    // gated extended requests and every priority level, for the core's
    // priority decode and for status
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            ext_req_o <= 6'h00;
            ext_prio_o <= 6'h00;
            base_prio_o <= 7'h00;
        end else begin
            ext_req_o <= ext_req_d;
            ext_prio_o <= ext_prio_d;
            base_prio_o <= base_prio_q;
        end
    end

    // request to the core: decoded every cycle and visible at the next edge,
    // which is the single cycle of detect latency before the vector call
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_req_o <= 1'b0;
            irq_high_o <= 1'b0;
        end else begin
            irq_req_o <= take_high | take_low;
            irq_high_o <= take_high;
        end
    end

endmodule

`default_nettype wire

/* File: logic/ipec_defines.vh */
// register addresses, field positions and reset values of the interrupt
// priority and extended-enable block
// assumes the core's special-function register bus carries 8-bit addresses
`ifndef IPEC_DEFINES_VH
`define IPEC_DEFINES_VH

// register addresses on the special-function bus
`define IPEC_ADDR_BASE_PRIO 8'hB8
`define IPEC_ADDR_PIN_CFG 8'hE4
`define IPEC_ADDR_EXT_EN 8'hE6
`define IPEC_ADDR_EXT_PRIO 8'hF6

// reset values
`define IPEC_RST_BASE_PRIO 8'h80
`define IPEC_RST_PIN_CFG 8'h01
`define IPEC_RST_EXT_EN 8'h00
`define IPEC_RST_EXT_PRIO 8'h00

// extended register bit positions
`define IPEC_BIT_TIMER3 7
`define IPEC_BIT_RSVD_HI 6
`define IPEC_BIT_COMPARATOR 5
`define IPEC_BIT_COUNTER_ARRAY 4
`define IPEC_BIT_CONV_DONE 3
`define IPEC_BIT_WINDOW_CMP 2
`define IPEC_BIT_RSVD_LO 1
`define IPEC_BIT_TWO_WIRE 0

// writable bits of the extended registers (reserved bits 6 and 1 held at zero)
`define IPEC_EXT_WMASK 8'hBD
// base priority: bit 7 unused, reads one
`define IPEC_BASE_UNUSED 8'h80

// pin configuration fields
`define IPEC_IN1_POL 7
`define IPEC_IN1_SEL_HI 6
`define IPEC_IN1_SEL_LO 4
`define IPEC_IN0_POL 3
`define IPEC_IN0_SEL_HI 2
`define IPEC_IN0_SEL_LO 0

// base source count and pending-request detect latency in cycles
`define IPEC_BASE_SRCS 7
`define IPEC_DETECT_CYCLES 1

`endif

/* File: sim/ipec_top_sva.sv */
// checker for the priority and extended-enable block, bound to its top
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module ipec_top_sva #(parameter PORT_W = 8) (
    // clock, reset and bus
    input wire logic sys_clk_i, srst_i, sfr_rd_i, global_irq_enable_i,
    input wire logic [7:0] sfr_addr_i, sfr_rdata_o,
    // core side and sources
    input wire logic svc_low_active_i, svc_high_active_i, irq_req_o, irq_high_o,
    input wire logic timer_three_low_ovf_i, timer_three_high_ovf_i,
    input wire logic [6:0] base_req_i,
    input wire logic [5:0] ext_req_o,
    input wire logic [PORT_W-1:0] port_zero_skip_mask_i, xbar_block_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    property p_base_top; sfr_rd_i && sfr_addr_i == 8'hB8 |=> sfr_rdata_o[7]; endproperty
    a_base_top: assert property (p_base_top) else $error("base top bit low");
    property p_rsvd;
        sfr_rd_i && sfr_addr_i[3:0] == 4'h6 |=> (sfr_rdata_o & 8'h42) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_glob; !global_irq_enable_i |=> !irq_req_o; endproperty
    a_glob: assert property (p_glob) else $error("request with global off");
    property p_hi_blk; svc_high_active_i |=> !irq_req_o; endproperty
    a_hi_blk: assert property (p_hi_blk) else $error("request during high service");
    property p_lo_blk; svc_low_active_i |=> !irq_req_o || irq_high_o; endproperty
    a_lo_blk: assert property (p_lo_blk) else $error("low request during service");
    property p_skip; 1 |=> xbar_block_o == $past(port_zero_skip_mask_i); endproperty
    a_skip: assert property (p_skip) else $error("skip mask not passed");
    property p_cause; irq_req_o |-> $past(|base_req_i) || (|ext_req_o); endproperty
    a_cause: assert property (p_cause) else $error("request without source");
    property p_t3;
        ext_req_o[5] |-> $past(timer_three_low_ovf_i || timer_three_high_ovf_i);
    endproperty
    a_t3: assert property (p_t3) else $error("timer three request without flag");
endmodule
bind ipec_top ipec_top_sva #(.PORT_W(PORT_W)) u_sva (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .sfr_rd_i(sfr_rd_i), .global_irq_enable_i(global_irq_enable_i), .sfr_addr_i(sfr_addr_i),
    .sfr_rdata_o(sfr_rdata_o), .svc_low_active_i(svc_low_active_i), .irq_req_o(irq_req_o),
    .svc_high_active_i(svc_high_active_i), .irq_high_o(irq_high_o), .base_req_i(base_req_i),
    .timer_three_low_ovf_i(timer_three_low_ovf_i), .ext_req_o(ext_req_o),
    .timer_three_high_ovf_i(timer_three_high_ovf_i), .xbar_block_o(xbar_block_o),
    .port_zero_skip_mask_i(port_zero_skip_mask_i));
`default_nettype wire

/* File: sim/ipec_core_model.sv */
// core model: takes a request and runs a routine of that level for len cycles
// assumes requests arrive as registered levels from the block
`timescale 1ns/1ns
`default_nettype none
module ipec_core_model (
    input wire logic clk_i, srst_i, req_i, high_i,
    input wire logic [2:0] len_i,
    output logic svc_low_o, svc_high_o
);
    logic [2:0] cnt_q;
    // service counter: a routine stays active until the count runs out
    always @(posedge clk_i) begin
        if (srst_i) begin
            {cnt_q, svc_low_o, svc_high_o} <= 5'h00;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            if (cnt_q == 3'h1) {svc_low_o, svc_high_o} <= 2'h0;
        end else if (req_i) begin
            cnt_q <= len_i;
            svc_high_o <= high_i;
            svc_low_o <= !high_i;
        end
    end
endmodule
`default_nettype wire

/* File: sim/interrupt_priority_enable_config_bench.sv */
// self-checking bench for the priority and extended-enable block
// inputs change 1 ns after the rising edge; reads are checked from a queue
`timescale 1ns/1ns
`default_nettype none
module interrupt_priority_enable_config_bench;
    logic clk, srst = 1, wr = 0, rd = 0, glob = 0, rd_seen = 0, ack, in0, in1, irq, irqh, slo, shi;
    logic [7:0] addr = 0, wd = 0, fl = 0, pins = 0, skip = 0, cfg, e, p, rdata, xb;
    logic [6:0] breq = 0, bprio;
    logic [5:0] ereq, eprio;
    logic [2:0] len = 1;
    logic [6:0] bprio_exp;
    logic [5:0] eq, ep;
    logic [1:0] sv;
    logic hi, lo;
    logic [31:0] s = 12, r;
    logic [7:0] exp_q[$];
    int failures = 0, n_tests = 0;
    ipec_top dut (.sys_clk_i(clk), .srst_i(srst), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata), .sfr_ack_o(ack),
        .global_irq_enable_i(glob), .base_req_i(breq), .timer_three_low_ovf_i(fl[7]),
        .timer_three_high_ovf_i(fl[6]), .comparator_rise_flag_i(fl[5]),
        .comparator_fall_flag_i(fl[4]), .counter_array_req_i(fl[3]), .conv_done_flag_i(fl[2]),
        .window_cmp_flag_i(fl[1]), .two_wire_req_i(fl[0]), .svc_low_active_i(slo),
        .svc_high_active_i(shi), .port_zero_pins_i(pins), .port_zero_skip_mask_i(skip),
        .ext_input_zero_o(in0), .ext_input_one_o(in1), .xbar_block_o(xb), .ext_req_o(ereq),
        .ext_prio_o(eprio), .base_prio_o(bprio), .irq_req_o(irq), .irq_high_o(irqh));
    ipec_core_model core (.clk_i(clk), .srst_i(srst), .req_i(irq), .high_i(irqh),
        .len_i(len), .svc_low_o(slo), .svc_high_o(shi));
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] ex);
        n_tests++;
        if (got !== ex) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, ex);
        end
    endtask
    // one bus cycle; strobes stay up for back-to-back cycles
    task automatic bus(input logic w, input logic [7:0] a, d, ex);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        if (!w) exp_q.push_back(ex);
        @(posedge clk);
        #1;
    endtask
    task automatic idle();
        wr = 0;
        rd = 0;
        @(posedge clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    // read monitor: oldest expected byte against each read answer
    always @(posedge clk) begin
        if (ack && rd_seen) chk(rdata, exp_q.pop_front());
        rd_seen <= rd;
    end
    initial begin
        #100000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 srst = 0;
        bus(0, 8'hB8, 0, 8'h80);
        bus(0, 8'hE4, 0, 8'h01);
        bus(0, 8'hE6, 0, 8'h00);
        bus(0, 8'hF6, 0, 8'h00);
        bus(1, 8'hA0, 8'hFF, 0);
        bus(0, 8'hA0, 0, 8'h00);
        // random enables, priorities and flags
        for (int i = 0; i < 24; i++) begin
            r = xs();
            e = r[7:0];
            p = r[15:8];
            glob = r[24];
            breq = r[31:25];
            len = r[2:0] | 3'h1;
            skip = r[15:8];
            bprio_exp = r[22:16];
            bus(1, 8'hE6, e & 8'hBD, 0);
            bus(1, 8'hF6, p, 0);
            bus(1, 8'hB8, r[23:16], 0);
            bus(0, 8'hE6, 0, e & 8'hBD);
            bus(0, 8'hF6, 0, p & 8'hBD);
            bus(0, 8'hB8, 0, r[23:16] | 8'h80);
            r = xs();
            fl = r[7:0];
            eq = {e[7] & (fl[7] | fl[6]), e[5] & (fl[5] | fl[4]), e[4] & fl[3], e[3] & fl[2],
                e[2] & fl[1], e[0] & fl[0]};
            ep = {p[7], p[5], p[4], p[3], p[2], p[0]};
            hi = glob && ((|(breq & bprio_exp)) || (|(eq & ep)));
            lo = glob && ((|(breq & ~bprio_exp)) || (|(eq & ~ep)));
            sv = {shi, slo};
            hi = hi && !sv[1];
            lo = lo && !sv[1] && !sv[0];
            idle();
            chk({2'b0, ereq}, {2'b0, eq});
            chk({2'b0, eprio}, {2'b0, ep});
            chk({1'b0, bprio}, {1'b0, bprio_exp});
            chk(xb, skip);
            chk({6'b0, irq, irqh}, {6'b0, hi || lo, hi});
        end
        // every pin code with both polarities
        for (int i = 0; i < 16; i++) begin
            r = xs();
            pins = r[7:0];
            cfg = {i[3], i[2:0], ~i[3], ~i[2:0]};
            bus(1, 8'hE4, cfg, 0);
            bus(0, 8'hE4, 0, cfg);
            idle();
            @(posedge clk);
            #1;
            chk({7'b0, in1}, {7'b0, cfg[7] ? pins[cfg[6:4]] : !pins[cfg[6:4]]});
            chk({7'b0, in0}, {7'b0, cfg[3] ? pins[cfg[2:0]] : !pins[cfg[2:0]]});
        end
        repeat (3) @(posedge clk);
        chk(8'(exp_q.size()), 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
